// [acp_pkg.sv]
/*
  Shared constants and types for the ATM cell path configuration
  controller: software register map, engine and PHY offsets, the fixed
  configuration values and the last step number of the boot sequence.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acp_pkg;

  // Software register map, byte addresses on the Wishbone side.
  localparam logic [7:0] ACP_CTRL_OFF = 8'h00;
  localparam logic [7:0] ACP_CMD_OFF  = 8'h04;
  localparam logic [7:0] ACP_ACCA_OFF = 8'h08;
  localparam logic [7:0] ACP_ACCD_OFF = 8'h0C;
  localparam logic [7:0] ACP_STAT_OFF = 8'h10;
  localparam logic [7:0] ACP_RDAT_OFF = 8'h14;
  localparam logic [31:0] ACP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ACP_ACCA_MASK = 32'h0001_33FF;

  // Field positions in the control, command and access registers.
  localparam int ACP_RX_ON_BIT     = 0;
  localparam int ACP_TX_ON_BIT     = 1;
  localparam int ACP_DISCARD_BIT   = 2;
  localparam int ACP_LOOP_BIT      = 14;
  localparam int ACP_H4_IDLE_BIT   = 16;
  localparam int ACP_FILT_BOTH_BIT = 17;
  localparam int ACP_START_BIT     = 0;
  localparam int ACP_GO_BIT        = 1;
  localparam int ACP_ACC_WR_BIT    = 16;

  // Indirect access targets.
  localparam logic [1:0] ACP_TGT_CMEM = 2'h0;
  localparam logic [1:0] ACP_TGT_ENG  = 2'h1;
  localparam logic [1:0] ACP_TGT_PHY  = 2'h3;

  // Engine general mode word.
  localparam logic [9:0]  ACP_MODE_OFF   = 10'h000;
  localparam logic [31:0] ACP_MODE_USER  = 32'h0000_4037;
  localparam logic [31:0] ACP_MODE_FIXED = 32'hC000_0F00;

  // PHY offsets and values.
  localparam logic [9:0] ACP_PHY_TOP_OFF  = 10'h000;
  localparam logic [9:0] ACP_RX_CONV_OFF  = 10'h028;
  localparam logic [9:0] ACP_TX_CONV_OFF  = 10'h02C;
  localparam logic [9:0] ACP_RX_CELL_OFF  = 10'h040;
  localparam logic [9:0] ACP_RX_FRM_OFF   = 10'h041;
  localparam logic [9:0] ACP_H4_PAT_OFF   = 10'h046;
  localparam logic [9:0] ACP_H1_MASK_OFF  = 10'h047;
  localparam logic [9:0] ACP_H2_MASK_OFF  = 10'h048;
  localparam logic [9:0] ACP_H4_MASK_OFF  = 10'h04A;
  localparam logic [7:0] ACP_PHY_TOP_VAL  = 8'h08;
  localparam logic [7:0] ACP_CONV_VAL     = 8'h80;
  localparam logic [7:0] ACP_RX_CELL_VAL  = 8'h28;
  localparam logic [7:0] ACP_RX_FRM_VAL   = 8'h01;
  localparam logic [7:0] ACP_H4_IDLE_VAL  = 8'h01;
  localparam logic [7:0] ACP_H4_UNAS_VAL  = 8'h00;
  localparam logic [7:0] ACP_MASK_ALL     = 8'hFF;
  localparam logic [7:0] ACP_MASK_BOTH    = 8'hFE;
  localparam logic [3:0] ACP_LAST_STEP    = 4'h9;

  typedef enum logic [1:0] {
    ACP_ST_IDLE = 2'b00,
    ACP_ST_SEQ  = 2'b01,
    ACP_ST_MAN  = 2'b10
  } acp_state_t;

  typedef enum logic [1:0] {
    ACP_LK_IDLE = 2'b00,
    ACP_LK_REQ  = 2'b01,
    ACP_LK_REL  = 2'b10,
    ACP_LK_DONE = 2'b11
  } acp_link_state_t;

endpackage

// [acp_acc_if.sv]
/*
  Request channel between the sequencer and the pin handshake module.
  The master holds valid and the request fields until done pulses.
*/
`timescale 1ns/1ps
interface acp_acc_if;
  logic        valid;
  logic        write;
  logic [1:0]  target;
  logic [9:0]  addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;
  modport master (output valid, write, target, addr, wdata,
                  input done, rdata);
  modport port (input valid, write, target, addr, wdata,
                output done, rdata);
endinterface

// [acp_link.sv]
/*
  Four-phase request/acknowledge driver for the engine's indirect
  access pins. Assumes the engine holds read data stable while its
  acknowledge is high, and returns acknowledge low after request falls.
*/
`timescale 1ns/1ps
module acp_link (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Request channel
  acp_acc_if.port          acc,
  // Engine pins
  output logic             eng_req,
  output logic             eng_wr,
  output logic [1:0]       eng_target,
  output logic [9:0]       eng_addr,
  output logic [31:0]      eng_wdata,
  input  wire logic        eng_ack,
  input  wire logic [31:0] eng_rdata
);

  typedef struct packed {
    acp_pkg::acp_link_state_t st;
    logic        ack_m;
    logic        ack_s;
    logic [31:0] rd_m;
    logic [31:0] rd_s;
    logic        req;
    logic        wr;
    logic [1:0]  tgt;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } acp_link_t;

  acp_link_t r_reg;
  acp_link_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.ack_m = eng_ack;
    r_next.ack_s = r_reg.ack_m;
    r_next.rd_m  = eng_rdata;
    r_next.rd_s  = r_reg.rd_m;
    case (r_reg.st)
      acp_pkg::ACP_LK_IDLE: begin
        if (acc.valid && !r_reg.ack_s) begin
          r_next.st    = acp_pkg::ACP_LK_REQ;
          r_next.req   = 1'b1;
          r_next.wr    = acc.write;
          r_next.tgt   = acc.target;
          r_next.addr  = acc.addr;
          r_next.wdata = acc.wdata;
        end
      end
      acp_pkg::ACP_LK_REQ: begin
        if (r_reg.ack_s) begin
          r_next.st    = acp_pkg::ACP_LK_REL;
          r_next.req   = 1'b0;
          r_next.rdata = r_reg.rd_s;
        end
      end
      acp_pkg::ACP_LK_REL: begin
        if (!r_reg.ack_s) begin
          r_next.st = acp_pkg::ACP_LK_DONE;
        end
      end
      acp_pkg::ACP_LK_DONE: r_next.st = acp_pkg::ACP_LK_IDLE;
      default: r_next.st = acp_pkg::ACP_LK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign eng_req    = r_reg.req;
  assign eng_wr     = r_reg.wr;
  assign eng_target = r_reg.tgt;
  assign eng_addr   = r_reg.addr;
  assign eng_wdata  = r_reg.wdata;
  assign acc.done   = (r_reg.st == acp_pkg::ACP_LK_DONE);
  assign acc.rdata  = r_reg.rdata;

  a_req_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
    eng_req && !r_reg.ack_s |=> $stable(eng_addr) && $stable(eng_wdata)
      && $stable(eng_target))
    else $error("request fields moved while waiting for acknowledge");

  a_done_single: assert property (@(posedge ref_clk) disable iff (!nrst)
    acc.done |=> !acc.done && !eng_req)
    else $error("done lasted more than one cycle");

endmodule

// [acp_cfg_ctrl.sv]
/*
  Host-side configuration controller for the ATM cell path. Software
  sets its choices over classic Wishbone and starts a boot sequence that
  writes the engine mode word and the PHY settings through the engine's
  indirect access pins; single manual accesses are also offered.
  Assumes one clock, and an engine that answers every request.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module acp_cfg_ctrl (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Engine indirect access pins
  output logic             eng_req,
  output logic             eng_wr,
  output logic [1:0]       eng_target,
  output logic [9:0]       eng_addr,
  output logic [31:0]      eng_wdata,
  input  wire logic        eng_ack,
  input  wire logic [31:0] eng_rdata
);

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    acp_pkg::acp_state_t st;
    logic [3:0]  step;
    logic [31:0] ctrl;
    logic [31:0] acca;
    logic [31:0] accd;
    logic [31:0] rdata;
    logic        cfg_done;
    logic        valid;
    logic        wr;
    logic [1:0]  tgt;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] dat;
  } acp_ctrl_t;

  acp_ctrl_t r_reg;
  acp_ctrl_t r_next;
  acp_acc_if acc ();

  // Byte-lane merge for Wishbone writes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Mode word: only the application bits and the free parity bits pass
  // from software; every other bit is forced, so a careless control
  // write can never enable bus parity or move the register map.
  function automatic logic [31:0] mode_word(input logic [31:0] c);
    return (c & acp_pkg::ACP_MODE_USER) | acp_pkg::ACP_MODE_FIXED;
  endfunction

  function automatic logic [9:0] step_addr(input logic [3:0] s);
    case (s)
      4'h0:    return acp_pkg::ACP_MODE_OFF;
      4'h1:    return acp_pkg::ACP_PHY_TOP_OFF;
      4'h2:    return acp_pkg::ACP_RX_CONV_OFF;
      4'h3:    return acp_pkg::ACP_TX_CONV_OFF;
      4'h4:    return acp_pkg::ACP_RX_CELL_OFF;
      4'h5:    return acp_pkg::ACP_RX_FRM_OFF;
      4'h6:    return acp_pkg::ACP_H4_PAT_OFF;
      4'h7:    return acp_pkg::ACP_H1_MASK_OFF;
      4'h8:    return acp_pkg::ACP_H2_MASK_OFF;
      default: return acp_pkg::ACP_H4_MASK_OFF;
    endcase
  endfunction

  function automatic logic [7:0] step_byte(input logic [3:0]  s,
                                           input logic [31:0] c);
    case (s)
      4'h1:    return acp_pkg::ACP_PHY_TOP_VAL;
      4'h2:    return acp_pkg::ACP_CONV_VAL;
      4'h3:    return acp_pkg::ACP_CONV_VAL;
      4'h4:    return acp_pkg::ACP_RX_CELL_VAL;
      4'h5:    return acp_pkg::ACP_RX_FRM_VAL;
      4'h6:    return c[acp_pkg::ACP_H4_IDLE_BIT] ?
                      acp_pkg::ACP_H4_IDLE_VAL : acp_pkg::ACP_H4_UNAS_VAL;
      4'h9:    return c[acp_pkg::ACP_FILT_BOTH_BIT] ?
                      acp_pkg::ACP_MASK_BOTH : acp_pkg::ACP_MASK_ALL;
      default: return acp_pkg::ACP_MASK_ALL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////

  logic        bus_wr;
  logic        bus_rd;
  logic        start;
  logic        go;
  logic [31:0] stat;

  always_comb begin
    r_next = r_reg;
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
    bus_wr = r_next.ack && wb_we_i;
    bus_rd = r_next.ack && !wb_we_i;
    start = 1'b0;
    go = 1'b0;
    stat = {24'h0, r_reg.step, 2'b00, r_reg.cfg_done,
            (r_reg.st != acp_pkg::ACP_ST_IDLE)};
    if (bus_rd) begin
      case (wb_adr_i)
        acp_pkg::ACP_CTRL_OFF: r_next.dat = r_reg.ctrl;
        acp_pkg::ACP_ACCA_OFF: r_next.dat = r_reg.acca;
        acp_pkg::ACP_ACCD_OFF: r_next.dat = r_reg.accd;
        acp_pkg::ACP_STAT_OFF: r_next.dat = stat;
        acp_pkg::ACP_RDAT_OFF: r_next.dat = r_reg.rdata;
        default:               r_next.dat = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      case (wb_adr_i)
        acp_pkg::ACP_CTRL_OFF: begin
          r_next.ctrl = merge(r_reg.ctrl, wb_dat_i, wb_sel_i);
        end
        acp_pkg::ACP_ACCA_OFF: begin
          r_next.acca = merge(r_reg.acca, wb_dat_i, wb_sel_i)
                        & acp_pkg::ACP_ACCA_MASK;
        end
        acp_pkg::ACP_ACCD_OFF: begin
          r_next.accd = merge(r_reg.accd, wb_dat_i, wb_sel_i);
        end
        acp_pkg::ACP_CMD_OFF: begin
          start = wb_sel_i[0] && wb_dat_i[acp_pkg::ACP_START_BIT];
          go    = wb_sel_i[0] && wb_dat_i[acp_pkg::ACP_GO_BIT];
        end
        default: ;
      endcase
    end

    // Commands arriving while busy are dropped; start wins over go.
    case (r_reg.st)
      acp_pkg::ACP_ST_IDLE: begin
        if (start) begin
          r_next.st       = acp_pkg::ACP_ST_SEQ;
          r_next.step     = 4'h0;
          r_next.cfg_done = 1'b0;
          r_next.valid    = 1'b1;
          r_next.wr       = 1'b1;
          r_next.tgt      = acp_pkg::ACP_TGT_ENG;
          r_next.addr     = acp_pkg::ACP_MODE_OFF;
          r_next.wdata    = mode_word(r_next.ctrl);
        end else if (go) begin
          r_next.st    = acp_pkg::ACP_ST_MAN;
          r_next.valid = 1'b1;
          r_next.wr    = r_reg.acca[acp_pkg::ACP_ACC_WR_BIT];
          r_next.tgt   = r_reg.acca[13:12];
          r_next.addr  = r_reg.acca[9:0];
          r_next.wdata = r_reg.accd;
        end
      end
      acp_pkg::ACP_ST_SEQ: begin
        if (acc.done) begin
          if (r_reg.step == acp_pkg::ACP_LAST_STEP) begin
            r_next.st       = acp_pkg::ACP_ST_IDLE;
            r_next.valid    = 1'b0;
            r_next.cfg_done = 1'b1;
          end else begin
            r_next.step  = r_reg.step + 4'h1;
            r_next.tgt   = acp_pkg::ACP_TGT_PHY;
            r_next.addr  = step_addr(r_next.step);
            r_next.wdata = {24'h0, step_byte(r_next.step, r_reg.ctrl)};
          end
        end
      end
      acp_pkg::ACP_ST_MAN: begin
        if (acc.done) begin
          r_next.st    = acp_pkg::ACP_ST_IDLE;
          r_next.valid = 1'b0;
          r_next.rdata = acc.rdata;
        end
      end
      default: begin
        r_next.st    = acp_pkg::ACP_ST_IDLE;
        r_next.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg      <= '0;
      r_reg.ctrl <= acp_pkg::ACP_CTRL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o  = r_reg.ack;
  assign wb_dat_o  = r_reg.dat;
  assign acc.valid  = r_reg.valid;
  assign acc.write  = r_reg.wr;
  assign acc.target = r_reg.tgt;
  assign acc.addr   = r_reg.addr;
  assign acc.wdata  = r_reg.wdata;

  acp_link u_link (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .acc        (acc.port),
    .eng_req    (eng_req),
    .eng_wr     (eng_wr),
    .eng_target (eng_target),
    .eng_addr   (eng_addr),
    .eng_wdata  (eng_wdata),
    .eng_ack    (eng_ack),
    .eng_rdata  (eng_rdata)
  );

  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic seq_mode;
  logic seq_phy;
  assign seq_mode = (r_reg.st == acp_pkg::ACP_ST_SEQ) && r_reg.step == 4'h0;
  assign seq_phy  = (r_reg.st == acp_pkg::ACP_ST_SEQ) && r_reg.step != 4'h0;

  // The link latches the word one cycle after the step starts, so the
  // pins are only judged while the request stands.
  a_mode_user: assert property (seq_mode && eng_req |->
    eng_wdata[0] == r_reg.ctrl[0] && eng_wdata[1] == r_reg.ctrl[1]
    && eng_wdata[2] == r_reg.ctrl[2] && eng_wdata[14] == r_reg.ctrl[14])
    else $error("mode word lost a software choice");

  a_mode_zeros: assert property (seq_mode && eng_req |->
    !eng_wdata[3] && eng_wdata[7:6] == 2'b00
    && eng_wdata[13:12] == 2'b00 && !eng_wdata[15])
    else $error("mode word has a forbidden bit set");

  a_mode_ones: assert property (seq_mode && eng_req |->
    eng_wdata[11:8] == 4'hF && eng_wdata[31:30] == 2'b11
    && eng_wdata[29:16] == 14'h0000)
    else $error("mode word fixed bits wrong");

  a_target_code: assert property (eng_req && r_reg.st == acp_pkg::ACP_ST_SEQ
    |-> eng_target == (seq_mode ? 2'h1 : 2'h3))
    else $error("wrong access target during boot sequence");

  a_phy_top: assert property (eng_req && seq_phy && eng_addr == 10'h000
    |-> eng_wdata == 32'h0000_0008)
    else $error("PHY top configuration value wrong");

  a_conv_cfg: assert property (eng_req && seq_phy
    && (eng_addr == 10'h028 || eng_addr == 10'h02C)
    |-> eng_wdata == 32'h0000_0080)
    else $error("convergence configuration value wrong");

  a_hdr_masks: assert property (eng_req && seq_phy
    && (eng_addr == 10'h047 || eng_addr == 10'h048)
    |-> eng_wdata == 32'h0000_00FF && eng_wr)
    else $error("H1 or H2 mask not all ones");

  a_seq_order: assert property (seq_phy && acc.done
    && r_reg.step != acp_pkg::ACP_LAST_STEP
    |=> r_reg.step == $past(r_reg.step) + 4'h1 && r_reg.valid)
    else $error("boot sequence skipped a step");

  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

  c_boot_done: cover property (seq_phy && acc.done
    && r_reg.step == acp_pkg::ACP_LAST_STEP ##1 r_reg.cfg_done);
  c_manual_rd: cover property (r_reg.st == acp_pkg::ACP_ST_MAN
    && !r_reg.wr && acc.done);
  c_busy_cmd: cover property (bus_wr && wb_adr_i == acp_pkg::ACP_CMD_OFF
    && r_reg.st != acp_pkg::ACP_ST_IDLE);

endmodule

// [acp_eng_model.sv]
/*
  Behavioural engine on the far side of the indirect access pins: engine
  registers, control memory and PHY register bytes, answering after a
  settable number of cycles. Assumes the four-phase request discipline.
*/
`timescale 1ns/1ps
module acp_eng_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Indirect access pins
  input  wire logic        eng_req,
  input  wire logic        eng_wr,
  input  wire logic [1:0]  eng_target,
  input  wire logic [9:0]  eng_addr,
  input  wire logic [31:0] eng_wdata,
  output logic             eng_ack,
  output logic [31:0]      eng_rdata,
  // Answer speed, in cycles
  input  wire logic [3:0]  ans_delay
);
  logic [31:0] eng_regs [1024];
  logic [31:0] cmem     [1024];
  logic [7:0]  phy      [1024];
  logic [3:0]  cnt;
  // PHY modes as decoded from its registers; no interrupt or loopback
  // source exists in this model, so those stay off.
  logic hec_cell_sync_on;
  logic header_coset_apply;
  logic rx_descramble_on;
  logic filt_idle;
  logic filt_unas;
  assign hec_cell_sync_on   = phy[10'h041][0];
  assign header_coset_apply = phy[10'h040][5];
  assign rx_descramble_on   = phy[10'h040][2];
  assign filt_idle = phy[10'h040][3] &&
    (((phy[10'h046] ^ 8'h01) & phy[10'h04A]) == 8'h00);
  assign filt_unas = phy[10'h040][3] &&
    ((phy[10'h046] & phy[10'h04A]) == 8'h00);

  // Each edge of ack answers the matching edge of req after ans_delay.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      eng_ack   <= 1'b0;
      eng_rdata <= 32'h0000_0000;
      cnt       <= 4'h0;
    end else if (eng_req != eng_ack) begin
      if (cnt < ans_delay) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt     <= 4'h0;
        eng_ack <= eng_req;
        if (!eng_req) begin
          // Released data lines do not keep the old value.
          eng_rdata <= ~eng_rdata;
        end else if (eng_wr) begin
          case (eng_target)
            2'b00: cmem[eng_addr] <= eng_wdata;
            2'b01: eng_regs[eng_addr] <= eng_wdata;
            2'b11: phy[eng_addr] <= eng_wdata[7:0];
            default: ;
          endcase
        end else begin
          case (eng_target)
            2'b00: eng_rdata <= cmem[eng_addr];
            2'b01: eng_rdata <= eng_regs[eng_addr];
            default: eng_rdata <= {24'h00_0000, phy[eng_addr]};
          endcase
        end
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule

// [atm_cell_path_config_test.sv]
/*
  Self-checking bench for the cell path configuration controller: drives
  Wishbone, runs boot sequences and manual accesses against the engine
  model. Assumes the design answers each Wishbone request within 20 edges.
*/
`timescale 1ns/1ps
module atm_cell_path_config_test;
  logic        ref_clk;
  logic        nrst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        eng_req;
  logic        eng_wr;
  logic [1:0]  eng_target;
  logic [9:0]  eng_addr;
  logic [31:0] eng_wdata;
  logic        eng_ack;
  logic [31:0] eng_rdata;
  logic [3:0]  ans_delay;
  logic [31:0] rd;
  int          num_errors;
  int          total_checks;

  acp_cfg_ctrl u_acp_cfg_ctrl (.ref_clk(ref_clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eng_req(eng_req),
    .eng_wr(eng_wr), .eng_target(eng_target), .eng_addr(eng_addr),
    .eng_wdata(eng_wdata), .eng_ack(eng_ack), .eng_rdata(eng_rdata));
  acp_eng_model u_acp_eng_model (.ref_clk(ref_clk), .nrst(nrst),
    .eng_req(eng_req), .eng_wr(eng_wr), .eng_target(eng_target),
    .eng_addr(eng_addr), .eng_wdata(eng_wdata), .eng_ack(eng_ack),
    .eng_rdata(eng_rdata), .ans_delay(ans_delay));

  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; read data is taken at the edge that sees ack.
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat, input logic [3:0] sel);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      print_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat, 4'hF);
  endtask

  task automatic wb_read(input logic [7:0] adr);
    wb_cycle(1'b0, adr, 32'h0000_0000, 4'hF);
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 200; n++) begin
      wb_read(8'h10);
      if (rd[0] === 1'b0) break;
    end
    if (n == 200) begin
      num_errors++;
      print_verdict();
    end
  endtask

  // Boot with the given choices, then inspect what reached the engine.
  task automatic run_boot(input logic [31:0] ctrl, input logic [3:0] dly);
    logic [31:0] mode;
    mode = (ctrl & 32'h0000_4037) | 32'hC000_0F00;
    ans_delay <= dly;
    wb_write(8'h00, ctrl);
    wb_write(8'h04, 32'h0000_0001);
    wb_write(8'h04, 32'h0000_0002);
    wb_read(8'h10);
    check("busy", rd[1:0], 32'h1);
    wait_idle();
    check("status", rd[1:0], 32'h2);
    check("mode", u_acp_eng_model.eng_regs[0], mode);
    check("mode hi", u_acp_eng_model.eng_regs[0][31:30], 32'h3);
    check("mode bursts", u_acp_eng_model.eng_regs[0][11:8], 32'hF);
    check("mode zeros", u_acp_eng_model.eng_regs[0] & 32'h3FFF_B0C8,
          32'h0);
    check("top", u_acp_eng_model.phy[10'h000], 32'h08);
    check("rx conv", u_acp_eng_model.phy[10'h028], 32'h80);
    check("tx conv", u_acp_eng_model.phy[10'h02C], 32'h80);
    check("cell", u_acp_eng_model.phy[10'h040], 32'h28);
    check("framing", u_acp_eng_model.phy[10'h041], 32'h01);
    check("h1 mask", u_acp_eng_model.phy[10'h047], 32'hFF);
    check("h2 mask", u_acp_eng_model.phy[10'h048], 32'hFF);
    check("h4 pat", u_acp_eng_model.phy[10'h046], {31'h0, ctrl[16]});
    check("h4 mask", u_acp_eng_model.phy[10'h04A],
          ctrl[17] ? 32'hFE : 32'hFF);
    check("idle filt", u_acp_eng_model.filt_idle,
          ctrl[17] | ctrl[16]);
    check("unas filt", u_acp_eng_model.filt_unas,
          {31'h0, ctrl[17] | ~ctrl[16]});
    check("hec_cell_sync_on", u_acp_eng_model.hec_cell_sync_on, 32'h1);
    check("coset", u_acp_eng_model.header_coset_apply, 32'h1);
    check("descr", u_acp_eng_model.rx_descramble_on, 32'h0);
  endtask

  task automatic manual(input logic [31:0] acca, input logic [31:0] wd);
    wb_write(8'h08, acca);
    wb_write(8'h0C, wd);
    wb_write(8'h04, 32'h0000_0002);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    ans_delay = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wb_read(8'h00);
    check("ctrl reset", rd, 32'h0000_0000);
    wb_read(8'h10);
    check("stat reset", rd, 32'h0000_0000);
    wb_read(8'h18);
    check("unmapped", rd, 32'h0000_0000);
    run_boot(32'h0002_4035, 4'h0);
    run_boot(32'h0001_FFFF, 4'h6);
    // Manual accesses to each target, slow engine throughout.
    manual(32'h0001_0155, 32'hA5A5_5A5A);
    manual(32'h0000_0155, 32'h0000_0000);
    wb_read(8'h14);
    check("cmem rd", rd, 32'hA5A5_5A5A);
    manual(32'h0001_1020, 32'h1234_5678);
    check("eng wr", u_acp_eng_model.eng_regs[10'h020], 32'h1234_5678);
    manual(32'h0000_3028, 32'h0000_0000);
    wb_read(8'h14);
    check("phy rd", rd, 32'h0000_0080);
    wb_write(8'h08, 32'hFFFF_FFFF);
    wb_read(8'h08);
    check("acca mask", rd, 32'h0001_33FF);
    wb_write(8'h18, 32'hFFFF_FFFF);
    wb_read(8'h00);
    check("ctrl kept", rd, 32'h0001_FFFF);
    wb_cycle(1'b1, 8'h00, 32'h00FF_0000, 4'h4);
    wb_read(8'h00);
    check("ctrl lane", rd, 32'h00FF_FFFF);
    print_verdict();
  end
endmodule
